// ---- design/ees_consts.vh ----
`ifndef EES_CONSTS_VH
`define EES_CONSTS_VH
// ----------------------------------------
// Register map, byte addresses on the AXI4-Lite bus
// ----------------------------------------
`define EES_REG_CTRL 8'h00
`define EES_REG_STATUS 8'h04
`define EES_CTRL_VARIANT 0
`define EES_RESP_OKAY 2'h0
`define EES_RESP_SLVERR 2'h2
// ----------------------------------------
// Array and select byte layout
// ----------------------------------------
`define EES_BLOCK_BYTES 256
`define EES_PTR_LOC 9'h1FF
`define EES_PTR_BIT 2
`define EES_MULTI_LEN 4'h4
`define EES_PAGE_LEN 4'h8
`define EES_CLK_NS 50
`endif

// ---- design/ees_front_end.v ----
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`include "ees_consts.vh"

// What this block does
// - Two 256-byte blocks, nine-bit address
// - Select byte: code, enables, block, direction
// - Answer only when enable bits match pins
// - Acknowledge low in ninth bit time
// - Read without address returns current byte
// - Sequential read continues while master acknowledges
// - Byte write accepted at any mode level
// - Mode high: up to four bytes
// - Mode low: up to eight bytes
// - Mode dynamic; unconnected reads as high
// - Write-control variant has no four-byte group; always up to eight
// - Write control high blocks programming
// - Unconnected write control reads as low
// - Protect pin plus pointer bit guards upper block
// - Power-on reset disables every operation
// - Data line open drain, never driven high
// - Programming cycle runs on internal timing
// - STOP after write starts programming
// - STOP after read: standby only after nack
// - Data sampled on serial clock rising edge
// - Ignore bus until START, except programming
module ees_front_end #(
    parameter [3:0] DEV_ID = 4'h5,      // Arbitrary identification code
    parameter PROG_TIME_NS = 500000,
    parameter AW = 8
) (
    input wire MCLK,
    input wire RST_N,
    input wire SCL,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE_N,
    input wire CHIP_SEL_LOW_INPUT,
    input wire CHIP_SEL_HIGH_INPUT,
    input wire PROTECT_ENABLE_INPUT,
    input wire MODE_INPUT,
    input wire WRITE_CONTROL_INPUT,
    input wire PIN7_OPEN,
    input wire [AW-1:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [AW-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    localparam [31:0] PROG_CYCLES_FULL = (PROG_TIME_NS + `EES_CLK_NS - 1) / `EES_CLK_NS;
    localparam [19:0] PROG_CYCLES = PROG_CYCLES_FULL[19:0];
    localparam [3:0] S_IDLE = 4'h0, S_DSEL = 4'h1, S_DACK = 4'h2, S_ADDR = 4'h3, S_AACK = 4'h4;
    localparam [3:0] S_WDAT = 4'h5, S_WACK = 4'h6, S_RDAT = 4'h7, S_RACK = 4'h8, S_NACK = 4'h9;
    localparam [3:0] S_PROG = 4'hA, S_HOLD = 4'hB;

    // ----------------------------------------
    // Storage: 2 x 256 bytes in flip-flops
    // ----------------------------------------
    reg [7:0] mem [0:2*`EES_BLOCK_BYTES-1];
    reg [7:0] wbuf [0:7];

    reg [7:0] sync1_ff, sync2_ff;
    reg scl_d_ff, sda_d_ff;
    reg [3:0] st_ff;
    reg [3:0] cnt_ff;
    reg [7:0] sh_ff;
    reg rw_ff, blk_ff, ack_ff;
    reg [8:0] addr_ff, base_ff;
    reg [3:0] nb_ff, lim_ff, pidx_ff;
    reg [2:0] wptr_ff;
    reg [19:0] prog_cnt_ff;
    reg variant_ff;
    reg [AW-1:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg aw_have_ff, w_have_ff;

    // Address of the n-th buffered byte: wraps inside the page or group
    function [8:0] wr_addr;
        input [8:0] base;
        input [3:0] n;
        input [3:0] lim;
        reg [8:0] mask;
        begin
            mask = {5'h00, lim - 4'h1};
            wr_addr = (base & ~mask) | ((base + {5'h00, n}) & mask);
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers and bus conditions
    // ----------------------------------------
    wire scl_s = sync2_ff[0];
    wire sda_s = sync2_ff[1];
    wire cel_s = sync2_ff[2];
    wire ceh_s = sync2_ff[3];
    wire pre_s = sync2_ff[4];
    wire mode_s = sync2_ff[5];
    wire wrctl_s = sync2_ff[6];
    wire open_s = sync2_ff[7];
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // Unconnected pin 7: mode reads high, write control reads low
    wire mode_eff = open_s | mode_s;
    wire wrctl_eff = variant_ff & ~open_s & wrctl_s;
    // Variant with write control loses the four-byte group
    wire multi = mode_eff & ~variant_ff;
    wire [3:0] lim_now = multi ? `EES_MULTI_LEN : `EES_PAGE_LEN;
    wire ptr_on = mem[`EES_PTR_LOC][`EES_PTR_BIT];
    wire [8:0] pa = wr_addr(base_ff, pidx_ff, lim_ff);
    // Upper block is guarded when the protect pin and pointer bit are both high
    wire blocked = pre_s & ptr_on & pa[8];
    wire mem_we = (st_ff == S_PROG) && (pidx_ff < nb_ff) && !blocked;
    wire [7:0] rd_byte = mem[addr_ff];
    wire sel_match = (sh_ff[7:4] == DEV_ID) && (sh_ff[3] == ceh_s) && (sh_ff[2] == cel_s);

    // Both stages catch pins outside the clock domain
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_ff <= 8'h03;
            sync2_ff <= 8'h03;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            sync1_ff <= {PIN7_OPEN, WRITE_CONTROL_INPUT, MODE_INPUT, PROTECT_ENABLE_INPUT,
                         CHIP_SEL_HIGH_INPUT, CHIP_SEL_LOW_INPUT, SDA_IN, SCL};
            sync2_ff <= sync1_ff;
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // Array has no reset: contents survive power-on reset
    always @(posedge MCLK) begin
        if (mem_we) begin
            mem[pa] <= wbuf[pidx_ff[2:0]];
        end
    end

    // ----------------------------------------
    // Serial protocol engine
    // ----------------------------------------
    // Reset is the power-on reset: everything idles, commands ignored
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= S_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            rw_ff <= 1'b0;
            blk_ff <= 1'b0;
            ack_ff <= 1'b0;
            addr_ff <= 9'h000;
            base_ff <= 9'h000;
            nb_ff <= 4'h0;
            lim_ff <= `EES_PAGE_LEN;
            wptr_ff <= 3'h0;
            pidx_ff <= 4'h0;
            prog_cnt_ff <= 20'h00000;
            SDA_OUT <= 1'b0;
            SDA_OE_N <= 1'b1;
        end else if (st_ff == S_PROG) begin
            // Self-timed; the bus is not watched until the cycle ends
            SDA_OE_N <= 1'b1;
            if (pidx_ff < nb_ff) begin
                pidx_ff <= pidx_ff + 4'h1;
            end
            if (prog_cnt_ff == PROG_CYCLES - 20'h00001) begin
                st_ff <= S_IDLE;
                addr_ff <= wr_addr(base_ff, nb_ff, lim_ff);
            end else begin
                prog_cnt_ff <= prog_cnt_ff + 20'h00001;
            end
        end else if (start_c) begin
            st_ff <= S_DSEL;
            cnt_ff <= 4'h0;
            SDA_OE_N <= 1'b1;
        end else if (stop_c) begin
            SDA_OE_N <= 1'b1;
            if ((st_ff == S_WDAT || st_ff == S_WACK) && nb_ff != 4'h0) begin
                pidx_ff <= 4'h0;
                prog_cnt_ff <= 20'h00000;
                st_ff <= wrctl_eff ? S_IDLE : S_PROG;
            end else if (st_ff == S_RDAT || st_ff == S_RACK) begin
                st_ff <= S_HOLD;
            end else begin
                st_ff <= S_IDLE;
            end
        end else begin
            case (st_ff)
                S_DSEL, S_ADDR, S_WDAT: begin
                    if (scl_rise) begin
                        sh_ff <= {sh_ff[6:0], sda_s};
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == 4'h8) begin
                        cnt_ff <= 4'h0;
                        SDA_OE_N <= 1'b0;
                        if (st_ff == S_DSEL) begin
                            if (sel_match) begin
                                rw_ff <= sh_ff[0];
                                blk_ff <= sh_ff[1];
                                st_ff <= S_DACK;
                            end else begin
                                SDA_OE_N <= 1'b1;
                                st_ff <= S_IDLE;
                            end
                        end else if (st_ff == S_ADDR) begin
                            addr_ff <= {blk_ff, sh_ff};
                            base_ff <= {blk_ff, sh_ff};
                            st_ff <= S_AACK;
                        end else begin
                            // Extra bytes roll over inside the buffer
                            wbuf[wptr_ff & (lim_ff[2:0] - 3'h1)] <= sh_ff;
                            wptr_ff <= wptr_ff + 3'h1;
                            if (nb_ff != lim_ff) begin
                                nb_ff <= nb_ff + 4'h1;
                            end
                            st_ff <= S_WACK;
                        end
                    end
                end
                S_DACK, S_AACK, S_WACK: begin
                    if (scl_rise) begin
                        cnt_ff <= 4'h1;
                    end else if (scl_fall && cnt_ff != 4'h0) begin
                        cnt_ff <= 4'h0;
                        if (st_ff == S_DACK && rw_ff) begin
                            SDA_OE_N <= rd_byte[7];
                            sh_ff <= {rd_byte[6:0], 1'b0};
                            st_ff <= S_RDAT;
                        end else begin
                            SDA_OE_N <= 1'b1;
                            if (st_ff == S_DACK) begin
                                st_ff <= S_ADDR;
                            end else begin
                                if (st_ff == S_AACK) begin
                                    nb_ff <= 4'h0;
                                    wptr_ff <= 3'h0;
                                    lim_ff <= lim_now;
                                end
                                st_ff <= S_WDAT;
                            end
                        end
                    end
                end
                S_RDAT: begin
                    if (scl_rise) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_ff == 4'h8) begin
                            SDA_OE_N <= 1'b1;
                            cnt_ff <= 4'h0;
                            addr_ff <= addr_ff + 9'h001;
                            st_ff <= S_RACK;
                        end else begin
                            SDA_OE_N <= sh_ff[7];
                            sh_ff <= {sh_ff[6:0], 1'b0};
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        ack_ff <= ~sda_s;
                        cnt_ff <= 4'h1;
                    end else if (scl_fall && cnt_ff != 4'h0) begin
                        cnt_ff <= 4'h0;
                        if (ack_ff) begin
                            SDA_OE_N <= rd_byte[7];
                            sh_ff <= {rd_byte[6:0], 1'b0};
                            st_ff <= S_RDAT;
                        end else begin
                            st_ff <= S_NACK;
                        end
                    end
                end
                default: begin
                    SDA_OE_N <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave: control and status
    // ----------------------------------------
    // Write address and data are taken in either order
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `EES_RESP_OKAY;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= {AW{1'b0}};
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            variant_ff <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                awaddr_ff <= S_AXI_AWADDR;
                aw_have_ff <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
                w_have_ff <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (aw_have_ff && w_have_ff && !S_AXI_BVALID) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (awaddr_ff == `EES_REG_CTRL) begin
                    S_AXI_BRESP <= `EES_RESP_OKAY;
                    if (wstrb_ff[0]) begin
                        variant_ff <= wdata_ff[`EES_CTRL_VARIANT];
                    end
                end else if (awaddr_ff == `EES_REG_STATUS) begin
                    S_AXI_BRESP <= `EES_RESP_OKAY; // Read-only, write ignored
                end else begin
                    S_AXI_BRESP <= `EES_RESP_SLVERR;
                end
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // Read answer one cycle after the address is taken
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `EES_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `EES_RESP_OKAY;
            if (S_AXI_ARADDR == `EES_REG_CTRL) begin
                S_AXI_RDATA <= {31'h00000000, variant_ff};
            end else if (S_AXI_ARADDR == `EES_REG_STATUS) begin
                S_AXI_RDATA <= {15'h0000, addr_ff, st_ff, 2'h0, st_ff == S_IDLE, st_ff == S_PROG};
            end else begin
                S_AXI_RDATA <= 32'h00000000;
                S_AXI_RRESP <= `EES_RESP_SLVERR;
            end
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

endmodule // ees_front_end

// ---- tb/ees_monitor.sv ----
`include "ees_consts.vh"
module ees_monitor #(
    parameter AW = 8
) (
    input wire MCLK,
    input wire RST_N,
    input wire SCL,
    input wire SDA_OUT,
    input wire SDA_OE_N,
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [AW-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // Handshake steps
    // ----------------------------------------
    sequence s_wboth;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rtake;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    // ----------------------------------------
    // Serial side
    // ----------------------------------------
    rst_idle_a: assert property ($rose(RST_N) |-> SDA_OE_N && S_AXI_AWREADY && !S_AXI_RVALID)
        else $error("outputs not idle after reset");
    sda_low_only_a: assert property (SDA_OUT == 1'b0)
        else $error("data line driven high");
    // The pin sync delay keeps device changes well inside the low phase
    sda_change_low_a: assert property ($changed(SDA_OE_N) |-> !SCL)
        else $error("data line changed while clock high");
    hold_low_a: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*8])
        else $error("acknowledge or data bit too short");
    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    // Both halves are latched first, so the response stands one edge later
    wresp_next_a: assert property (s_wboth |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("write response late");
    wready_back_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
        else $error("write channel not reopened");
    rresp_next_a: assert property (s_rtake |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read response late");
    unmapped_rd_a: assert property (s_rtake ##0 (S_AXI_ARADDR > `EES_REG_STATUS)
        |=> S_AXI_RRESP == `EES_RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
endmodule // ees_monitor

// ---- tb/ees_i2c_master.sv ----
module ees_i2c_master (
    input wire mclk,
    input wire sda,
    output logic scl,
    output logic sda_m
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus idles released; the line pull-up makes that a high level
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Half period of eight MCLK, twice the floor the sync pipeline needs
    task automatic hp;
        repeat (8) @(posedge mclk);
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_m <= b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda;
        scl <= 1'b0;
        hp();
    endtask
    task automatic start;
        sda_m <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= 1'b0;
        hp();
        scl <= 1'b0;
        hp();
    endtask
    task automatic stop;
        sda_m <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= 1'b1;
        hp();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(nack, r);
    endtask
endmodule // ees_i2c_master

// ---- tb/ees_front_end_bench.sv ----
`include "ees_consts.vh"
module ees_front_end_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] ID = 4'h6; // Arbitrary identification code
    logic MCLK = 1'b0, RST_N = 1'b0, CHIP_SEL_LOW_INPUT = 1'b0, CHIP_SEL_HIGH_INPUT = 1'b1;
    logic PROTECT_ENABLE_INPUT = 1'b0, MODE_INPUT = 1'b1, WRITE_CONTROL_INPUT = 1'b0, PIN7_OPEN = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    wire SCL, SDA_OUT, SDA_OE_N, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, sda_m;
    wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
    wire [31:0] S_AXI_RDATA;
    int fails = 0, n_checks = 0;
    // Open-drain wire with pull-up: low if either party pulls
    wire SDA_IN = sda_m & (SDA_OE_N | SDA_OUT);
    ees_front_end #(.DEV_ID(ID), .PROG_TIME_NS(20000)) i_dut (.MCLK, .RST_N, .SCL, .SDA_IN, .SDA_OUT, .SDA_OE_N,
        .CHIP_SEL_LOW_INPUT, .CHIP_SEL_HIGH_INPUT, .PROTECT_ENABLE_INPUT, .MODE_INPUT, .WRITE_CONTROL_INPUT,
        .PIN7_OPEN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
        .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
        .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
    ees_i2c_master i_mst (.mclk(MCLK), .sda(SDA_IN), .scl(SCL), .sda_m(sda_m));
    always #25 MCLK = ~MCLK;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge MCLK);
        {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'b111};
        do begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, S_AXI_BRESP});
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        @(posedge MCLK);
        {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
        do begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
        chk("rdata", e, S_AXI_RDATA & m);
        chk("rresp", {30'h0, er}, {30'h0, S_AXI_RRESP});
    endtask
    function automatic logic [7:0] sel(input logic rw, input logic b);
        return {ID, CHIP_SEL_HIGH_INPUT, CHIP_SEL_LOW_INPUT, b, rw};
    endfunction
    // Start plus select byte; a high ack bit means nobody answered
    task automatic sel_open(input logic [7:0] s, input logic nak);
        logic k;
        i_mst.start();
        i_mst.wbyte(s, k);
        chk("select ack", {31'h0, nak}, {31'h0, k});
    endtask
    // Each transfer first waits out any programming cycle still running
    task automatic wr(input logic [8:0] a, input int n, input logic [7:0] v);
        logic k;
        repeat (450) @(posedge MCLK);
        sel_open(sel(1'b0, a[8]), 1'b0);
        i_mst.wbyte(a[7:0], k);
        for (int i = 0; i < n; i++) begin
            i_mst.wbyte(v + 8'(i), k);
            chk("data ack", 32'h0, {31'h0, k});
        end
        i_mst.stop();
    endtask
    task automatic rd(input logic [8:0] a, input int n, input logic [63:0] e);
        logic k;
        logic [7:0] d;
        repeat (450) @(posedge MCLK);
        sel_open(sel(1'b0, a[8]), 1'b0);
        i_mst.wbyte(a[7:0], k);
        sel_open(sel(1'b1, a[8]), 1'b0);
        for (int i = 0; i < n; i++) begin
            i_mst.rbyte(i == n - 1, d);
            chk("read byte", {24'h0, e[8*i+:8]}, {24'h0, d});
        end
        i_mst.stop();
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        repeat (2) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (6) @(posedge MCLK);
        axr(`EES_REG_CTRL, 32'h0, 32'hFFFFFFFF, `EES_RESP_OKAY);
        axr(8'h08, 32'h0, 32'hFFFFFFFF, `EES_RESP_SLVERR);
        axw(8'h0C, 32'h1, `EES_RESP_SLVERR);
        sel_open({ID, 2'b01, 2'b00}, 1'b1);
        i_mst.stop();
        sel_open({4'h9, 2'b10, 2'b00}, 1'b1);
        i_mst.stop();
        wr(9'h105, 1, 8'hA5);
        axr(`EES_REG_STATUS, 32'h1, 32'h1, `EES_RESP_OKAY);
        sel_open(sel(1'b0, 1'b0), 1'b1);
        i_mst.stop();
        repeat (450) @(posedge MCLK);
        axr(`EES_REG_STATUS, 32'h0, 32'h1, `EES_RESP_OKAY);
        rd(9'h105, 1, 64'hA5);
        wr(9'h010, 5, 8'h10);
        rd(9'h010, 3, 64'h121114);
        sel_open(sel(1'b1, 1'b0), 1'b0);
        i_mst.rbyte(1'b1, d);
        chk("current read", 32'h13, {24'h0, d});
        i_mst.stop();
        MODE_INPUT <= 1'b0;
        wr(9'h020, 9, 8'h20);
        rd(9'h020, 8, 64'h2726252423222128);
        // Only byte lane 0 reaches the variant bit
        S_AXI_WSTRB <= 4'hE;
        axw(`EES_REG_CTRL, 32'h1, `EES_RESP_OKAY);
        axr(`EES_REG_CTRL, 32'h0, 32'hFFFFFFFF, `EES_RESP_OKAY);
        S_AXI_WSTRB <= 4'hF;
        axw(`EES_REG_CTRL, 32'h1, `EES_RESP_OKAY);
        axr(`EES_REG_CTRL, 32'h1, 32'hFFFFFFFF, `EES_RESP_OKAY);
        MODE_INPUT <= 1'b1;
        wr(9'h030, 5, 8'h30);
        rd(9'h030, 5, 64'h3433323130);
        WRITE_CONTROL_INPUT <= 1'b1;
        wr(9'h105, 1, 8'h5A);
        rd(9'h105, 1, 64'hA5);
        PIN7_OPEN <= 1'b1;
        wr(9'h1FF, 1, 8'h04);
        PROTECT_ENABLE_INPUT <= 1'b1;
        wr(9'h105, 1, 8'h77);
        rd(9'h1FF, 1, 64'h04);
        rd(9'h105, 1, 64'hA5);
        give_verdict();
    end
    // Watchdog, about three times the expected run length
    initial begin
        repeat (90000) @(posedge MCLK);
        fails++;
        give_verdict();
    end
endmodule // ees_front_end_bench
bind ees_front_end ees_monitor #(.AW(AW)) i_mon (.MCLK(MCLK), .RST_N(RST_N), .SCL(SCL), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID));
